// ===== ctc_host.sv
// apb-driven controller that runs compare, write, clear and read cycles on the tag store pins
`timescale 1ns/10ps
`include "ctc_map.svh"

module ctc_host #(
    parameter int IDX_W     = 13,
    parameter int TAG_W     = 9,
    parameter int VALID_BIT = 8
) (
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // interrupt
    output logic                   irq,
    // tag store pins
    output logic      [IDX_W-1:0]  index_in,
    output logic      [TAG_W-1:0]  tag_in,
    input  wire logic [TAG_W-1:0]  tag_out,
    input  wire logic              match,
    output logic                   sel,
    output logic                   sel_n,
    output logic                   write_n,
    output logic                   word_clear_n,
    output logic                   clear_n,
    output logic                   out_en_n,
    // open-drain parity error pin
    input  wire logic              parity_error_n_i,
    output logic                   parity_error_n_o,
    output logic                   parity_error_n_oe
);
    import ctc_pkg::*;

    localparam int TW = 8;
    localparam logic [TW-1:0] CYC_MCLR = TW'(`CTC_CYC(`CTC_T_MCLR_NS));
    localparam logic [TW-1:0] CYC_WR   = TW'(`CTC_CYC(`CTC_T_WRITE_NS));
    localparam logic [TW-1:0] CYC_WCLR = TW'(`CTC_CYC(`CTC_T_WCLEAR_NS));
    localparam logic [TW-1:0] CYC_CMP  = TW'(`CTC_CYC(`CTC_T_CMP_NS) + `CTC_SYNC_DEPTH);
    localparam logic [TW-1:0] CYC_RD   = TW'(`CTC_CYC(`CTC_T_READ_NS) + `CTC_SYNC_DEPTH);

    // refuse shapes the register layout cannot carry
    generate
        if (IDX_W < 1 || IDX_W > 16 || TAG_W < 1 || TAG_W > 12 || VALID_BIT >= TAG_W) begin : g_bad
            $error("ctc_host: unsupported index or tag width");
        end
    endgenerate

    // apb side state
    logic                  pready_r;
    logic [31:0]           prdata_r;
    logic                  pslverr_r;
    logic                  acc;
    logic                  wr_fire;
    logic                  hit_addr;
    logic [31:0]           rd_mux;

    // software registers
    ctc_op_t               op_r;
    logic                  force_pe_r;
    logic [IDX_W-1:0]      index_r;
    logic [TAG_W-1:0]      tag_r;
    logic                  last_hit_r;
    logic                  last_perr_r;
    logic [TAG_W-1:0]      rdata_r;
    logic [`CTC_INT_W-1:0] int_stat_r;
    logic [`CTC_INT_W-1:0] int_mask_r;
    logic [`CTC_INT_W-1:0] ev;
    logic                  irq_r;
    logic                  start;

    // sequencer
    ctc_state_t            state_r;
    ctc_op_t               run_op_r;
    logic                  tmr_load;
    logic [TW-1:0]         tmr_val;
    logic                  tmr_exp;

    // pin flops
    logic [IDX_W-1:0]      index_in_r;
    logic [TAG_W-1:0]      tag_in_r;
    logic                  sel_r;
    logic                  sel_n_r;
    logic                  write_n_r;
    logic                  word_clear_n_r;
    logic                  clear_n_r;
    logic                  out_en_n_r;
    logic                  pe_oe_r;

    // synchronised pins
    logic [TAG_W-1:0]      tag_out_s;
    logic                  match_s;
    logic                  pe_n_s;

    ctc_sync #(
        .W       (TAG_W + 2),
        .RST_VAL ({{TAG_W{1'b0}}, 2'b11})
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d_async ({tag_out, match, parity_error_n_i}),
        .q_sync  ({tag_out_s, match_s, pe_n_s})
    );

    ctc_timer #(
        .CW      (TW)
    ) u_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .load    (tmr_load),
        .value   (tmr_val),
        .expired (tmr_exp)
    );

    // access phase answered one cycle late so prdata can come from a flop
    assign acc     = psel && penable && !pready_r;
    assign wr_fire = psel && penable && pready_r && pwrite;
    assign start   = wr_fire && (paddr == `CTC_REG_CTRL) && pwdata[`CTC_CTRL_START]
                     && (state_r == ST_IDLE);

    // read decode, unmapped reads as zero
    always_comb begin
        rd_mux   = 32'h0000_0000;
        hit_addr = 1'b1;
        case (paddr)
            `CTC_REG_CTRL: begin
                rd_mux[`CTC_CTRL_OP_MSB:`CTC_CTRL_OP_LSB] = op_r;
                rd_mux[`CTC_CTRL_FORCE_PE]                = force_pe_r;
            end
            `CTC_REG_INDEX:    rd_mux[IDX_W-1:0] = index_r;
            `CTC_REG_TAG:      rd_mux[TAG_W-1:0] = tag_r;
            `CTC_REG_STATUS: begin
                rd_mux[`CTC_ST_BUSY] = (state_r != ST_IDLE);
                rd_mux[`CTC_ST_HIT]  = last_hit_r;
                rd_mux[`CTC_ST_PERR] = last_perr_r;
                rd_mux[`CTC_ST_OP_LSB +: 3] = run_op_r;
            end
            `CTC_REG_RDATA:    rd_mux[TAG_W-1:0] = rdata_r;
            `CTC_REG_INT_STAT: rd_mux[`CTC_INT_W-1:0] = int_stat_r;
            `CTC_REG_INT_MASK: rd_mux[`CTC_INT_W-1:0] = int_mask_r;
            default:           hit_addr = 1'b0;
        endcase
    end

    // apb answer flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else begin
            pready_r  <= acc;
            if (acc) begin
                prdata_r  <= pwrite ? 32'h0000_0000 : rd_mux;
                pslverr_r <= !hit_addr;
            end else begin
                pslverr_r <= 1'b0;
            end
        end
    end

    // software-written configuration; index and tag are latched onto pins at start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_r       <= `CTC_OP_COMPARE;
            force_pe_r <= 1'b0;
            index_r    <= IDX_W'(`CTC_INDEX_RST);
            tag_r      <= TAG_W'(`CTC_TAG_RST);
            int_mask_r <= `CTC_INT_MASK_RST;
        end else if (wr_fire) begin
            case (paddr)
                `CTC_REG_CTRL: begin
                    op_r       <= pwdata[`CTC_CTRL_OP_MSB:`CTC_CTRL_OP_LSB];
                    force_pe_r <= pwdata[`CTC_CTRL_FORCE_PE];
                end
                `CTC_REG_INDEX:    index_r    <= pwdata[IDX_W-1:0];
                `CTC_REG_TAG:      tag_r      <= pwdata[TAG_W-1:0];
                `CTC_REG_INT_MASK: int_mask_r <= pwdata[`CTC_INT_W-1:0];
                default: ;
            endcase
        end
    end

    // events of a finished cycle; device outputs are only trusted after settle plus sync
    always_comb begin
        ev = '0;
        if (state_r == ST_SAMPLE) begin
            ev[`CTC_INT_DONE] = 1'b1;
            if (run_op_r == `CTC_OP_COMPARE) begin
                ev[`CTC_INT_HIT]  = match_s;
                ev[`CTC_INT_MISS] = !match_s;
            end
            if ((run_op_r == `CTC_OP_COMPARE || run_op_r == `CTC_OP_READ) && !pe_n_s) begin
                ev[`CTC_INT_PERR] = 1'b1;
            end
        end else if (state_r == ST_HOLD) begin
            ev[`CTC_INT_DONE] = 1'b1;
        end
    end

    // sticky status, write one to clear; a same-cycle event wins over the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_stat_r <= '0;
        end else if (wr_fire && paddr == `CTC_REG_INT_STAT) begin
            int_stat_r <= (int_stat_r & ~pwdata[`CTC_INT_W-1:0]) | ev;
        end else begin
            int_stat_r <= int_stat_r | ev;
        end
    end

    // level interrupt, one cycle behind the status so irq comes from a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(int_stat_r & int_mask_r);
        end
    end

    // results of the last compare or read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_hit_r  <= 1'b0;
            last_perr_r <= 1'b0;
            rdata_r     <= '0;
        end else if (state_r == ST_SAMPLE) begin
            last_perr_r <= !pe_n_s;
            if (run_op_r == `CTC_OP_COMPARE) begin
                last_hit_r <= match_s;
            end
            if (run_op_r == `CTC_OP_READ) begin
                rdata_r <= tag_out_s;
            end
        end
    end

    // strobe width or settle time for the running op
    always_comb begin
        tmr_load = (state_r == ST_SETUP);
        case (run_op_r)
            `CTC_OP_WRITE:  tmr_val = CYC_WR;
            `CTC_OP_WCLEAR: tmr_val = CYC_WCLR;
            `CTC_OP_READ:   tmr_val = CYC_RD;
            `CTC_OP_MCLEAR: tmr_val = CYC_MCLR;
            default:        tmr_val = CYC_CMP;
        endcase
    end

    // cycle sequencer: setup pins, strobe or settle, release, then hold or sample
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r  <= ST_IDLE;
            run_op_r <= `CTC_OP_COMPARE;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (start) begin
                        run_op_r <= pwdata[`CTC_CTRL_OP_MSB:`CTC_CTRL_OP_LSB];
                        state_r  <= ST_SETUP;
                    end
                end
                ST_SETUP:  state_r <= ST_STROBE;
                ST_STROBE: begin
                    if (tmr_exp) begin
                        if (run_op_r == `CTC_OP_COMPARE || run_op_r == `CTC_OP_READ) begin
                            state_r <= ST_SAMPLE;
                        end else begin
                            state_r <= ST_HOLD;
                        end
                    end
                end
                ST_HOLD:   state_r <= ST_IDLE;
                ST_SAMPLE: state_r <= ST_IDLE;
                default:   state_r <= ST_IDLE;
            endcase
        end
    end

    // address and tag pins; valid bit forced high so cleared entries miss
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            index_in_r <= '0;
            tag_in_r   <= '0;
        end else if (start) begin
            index_in_r <= index_r;
            tag_in_r   <= tag_r | (TAG_W'(1) << VALID_BIT);
        end
    end

    // select held through the whole cycle; idle leaves the device deselected so its hit floats high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_r   <= 1'b0;
            sel_n_r <= 1'b1;
        end else if (start) begin
            sel_r   <= 1'b1;
            sel_n_r <= 1'b0;
        end else if (state_r == ST_HOLD || state_r == ST_SAMPLE) begin
            sel_r   <= 1'b0;
            sel_n_r <= 1'b1;
        end
    end

    // active-low strobes asserted for the timed width, address stable around them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            write_n_r      <= 1'b1;
            word_clear_n_r <= 1'b1;
            clear_n_r      <= 1'b1;
            out_en_n_r     <= 1'b1;
            pe_oe_r        <= 1'b0;
        end else if (state_r == ST_SETUP) begin
            write_n_r      <= !(run_op_r == `CTC_OP_WRITE);
            word_clear_n_r <= !(run_op_r == `CTC_OP_WCLEAR);
            clear_n_r      <= !(run_op_r == `CTC_OP_MCLEAR);
            out_en_n_r     <= !(run_op_r == `CTC_OP_READ);
            pe_oe_r        <= (run_op_r == `CTC_OP_WRITE) && force_pe_r;
        end else if (state_r == ST_STROBE && tmr_exp) begin
            // release before deselect gives the device its hold time
            write_n_r      <= 1'b1;
            word_clear_n_r <= 1'b1;
            clear_n_r      <= 1'b1;
            out_en_n_r     <= 1'b1;
            pe_oe_r        <= 1'b0;
        end
    end

    // hit is not sampled after a master clear: selected, it reads low anyway

    assign prdata            = prdata_r;
    assign pready            = pready_r;
    assign pslverr           = pslverr_r;
    assign irq               = irq_r;
    assign index_in          = index_in_r;
    assign tag_in            = tag_in_r;
    assign sel               = sel_r;
    assign sel_n             = sel_n_r;
    assign write_n           = write_n_r;
    assign word_clear_n      = word_clear_n_r;
    assign clear_n           = clear_n_r;
    assign out_en_n          = out_en_n_r;
    assign parity_error_n_o  = 1'b0;
    assign parity_error_n_oe = pe_oe_r;
endmodule : ctc_host

// ===== ctc_map.svh
// register offsets, field positions, opcodes and timing counts of the tag store controller
`ifndef CTC_MAP_SVH
`define CTC_MAP_SVH

// register byte offsets on the apb side
`define CTC_REG_CTRL      8'h00
`define CTC_REG_INDEX     8'h04
`define CTC_REG_TAG       8'h08
`define CTC_REG_STATUS    8'h0C
`define CTC_REG_RDATA     8'h10
`define CTC_REG_INT_STAT  8'h14
`define CTC_REG_INT_MASK  8'h18

// control register fields
`define CTC_CTRL_START    0
`define CTC_CTRL_OP_LSB   1
`define CTC_CTRL_OP_MSB   3
`define CTC_CTRL_FORCE_PE 4

// operation codes in the control op field
`define CTC_OP_COMPARE    3'h0
`define CTC_OP_WRITE      3'h1
`define CTC_OP_WCLEAR     3'h2
`define CTC_OP_READ       3'h3
`define CTC_OP_MCLEAR     3'h4

// status register fields
`define CTC_ST_BUSY       0
`define CTC_ST_HIT        1
`define CTC_ST_PERR       2
`define CTC_ST_OP_LSB     4

// interrupt status and mask fields
`define CTC_INT_DONE      0
`define CTC_INT_HIT       1
`define CTC_INT_MISS      2
`define CTC_INT_PERR      3
`define CTC_INT_W         4

// reset values
`define CTC_INT_MASK_RST  4'h0
`define CTC_TAG_RST       9'h000
`define CTC_INDEX_RST     13'h0000

// timing in ns and derived pclk cycles, least times rounded up
`define CTC_CLK_NS        100
`define CTC_T_MCLR_NS     60
`define CTC_T_WRITE_NS    20
`define CTC_T_WCLEAR_NS   15
`define CTC_T_CMP_NS      25
`define CTC_T_READ_NS     24
`define CTC_CYC(ns)       (((ns) + `CTC_CLK_NS - 1) / `CTC_CLK_NS)
`define CTC_SYNC_DEPTH    2

`endif

// ===== ctc_pkg.sv
// types shared by the tag store controller
package ctc_pkg;

    typedef logic [2:0] ctc_op_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETUP,
        ST_STROBE,
        ST_HOLD,
        ST_SAMPLE
    } ctc_state_t;

endpackage : ctc_pkg

// ===== ctc_sync.sv
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/10ps

module ctc_sync #(
    parameter int W        = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // asynchronous pins and their synchronised copy
    input  wire logic [W-1:0] d_async,
    output logic      [W-1:0] q_sync
);
    logic [W-1:0] meta_r;

    // first stage is read only by the second stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= RST_VAL;
            q_sync <= RST_VAL;
        end else begin
            meta_r <= d_async;
            q_sync <= meta_r;
        end
    end
endmodule : ctc_sync

// ===== ctc_timer.sv
// down counter timing strobe widths and settle waits
`timescale 1ns/10ps

module ctc_timer #(
    parameter int CW = 8
) (
    // clock and reset
    input  wire logic          pclk,
    input  wire logic          presetn,
    // load and expiry
    input  wire logic          load,
    input  wire logic [CW-1:0] value,
    output logic               expired
);
    logic [CW-1:0] cnt_r;

    // counts down to zero and stops there
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= '0;
        end else if (load) begin
            cnt_r <= value;
        end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
        end
    end

    assign expired = (cnt_r == '0) && !load;
endmodule : ctc_timer

// ===== ctc_tag_model.sv
// behavioural tag store: 8k entries of nine tag bits plus odd parity
`timescale 1ns/10ps
module ctc_tag_model (
    // entry address and data
    input  wire logic [12:0] index_in,
    input  wire logic [8:0]  tag_in,
    output logic      [8:0]  tag_out,
    // selects and active-low strobes
    input  wire logic        sel,
    input  wire logic        sel_n,
    input  wire logic        write_n,
    input  wire logic        word_clear_n,
    input  wire logic        clear_n,
    input  wire logic        out_en_n,
    // hit output and open-drain parity line
    output logic             match,
    input  wire logic        pe_level_n,
    output logic             pe_pull
);
    logic [9:0] mem [0:8191];
    logic [9:0] ent;
    logic [8:0] last_q = 9'h000;
    logic       wr_q   = 1'b1;
    logic       frc    = 1'b0;
    logic       on;

    // no clock: strobes act as levels, outputs follow inputs and contents
    always @(index_in, tag_in, sel, sel_n, write_n, word_clear_n, clear_n, out_en_n, pe_level_n) begin
        on = sel && !sel_n;
        // a force seen during a write sticks, so the order of release cannot undo it
        if (wr_q && !write_n)
            frc = 1'b0;
        // our own parity pull left over from before the write is not a force
        if (!write_n && !pe_level_n && !pe_pull)
            frc = 1'b1;
        wr_q = write_n;
        if (!clear_n) begin
            for (int i = 0; i < 8192; i++)
                mem[i] = 10'h200;
        end else if (on && !write_n) begin
            mem[index_in] = {frc ? ^tag_in : ~^tag_in, tag_in};
        end else if (on && !word_clear_n) begin
            mem[index_in] = 10'h200;
        end
        ent = mem[index_in];
        if (!on)
            match = 1'b1;
        else if (!clear_n || !write_n || !word_clear_n)
            match = 1'b0;
        else
            match = (ent == {~^tag_in, tag_in});
        pe_pull = on && clear_n && write_n && word_clear_n && !(^ent);
        if (on && write_n && !out_en_n)
            last_q = ent[8:0];
        // released data pins show the inverse of the last value, never a stale copy
        tag_out = (on && write_n && !out_en_n) ? ent[8:0] : ~last_q;
    end
endmodule : ctc_tag_model

// ===== ctc_host_checker.sv
// assertions on the tag store pins driven by the controller
`timescale 1ns/10ps
module ctc_host_checker #(
    parameter int IDX_W     = 13,
    parameter int TAG_W     = 9,
    parameter int VALID_BIT = 8
) (
    // clock and reset
    input wire logic             pclk,
    input wire logic             presetn,
    // tag store pins
    input wire logic [IDX_W-1:0] index_in,
    input wire logic [TAG_W-1:0] tag_in,
    input wire logic             sel,
    input wire logic             sel_n,
    input wire logic             write_n,
    input wire logic             word_clear_n,
    input wire logic             clear_n,
    input wire logic             out_en_n,
    input wire logic             parity_error_n_oe
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    AST_VALID_FLAG: assert property (sel |-> tag_in[VALID_BIT])
        else $error("valid flag low while selected");
    AST_ONE_SELECT: assert property (sel_n != sel)
        else $error("select pair not complementary");
    AST_WRITE_SETUP: assert property (!write_n |-> sel && $stable(index_in) && $stable(tag_in))
        else $error("write without stable address");
    AST_WRITE_PULSE: assert property ($fell(write_n) |=> !write_n ##1 write_n)
        else $error("write strobe width wrong");
    AST_WRITE_HOLD: assert property ($rose(write_n) |-> sel)
        else $error("select dropped with write strobe");
    AST_WCLR_PULSE: assert property ($fell(word_clear_n) |-> sel ##1 !word_clear_n && sel ##1 word_clear_n && sel)
        else $error("bad word clear strobe");
    AST_MCLR_PULSE: assert property ($fell(clear_n) |=> !clear_n ##1 clear_n)
        else $error("master clear width wrong");
    AST_PE_DRIVE: assert property (parity_error_n_oe |-> !write_n && sel)
        else $error("parity line driven outside write");
    AST_READ_ENABLE: assert property (!out_en_n |-> sel && write_n && word_clear_n)
        else $error("output enable outside read");
endmodule : ctc_host_checker

bind ctc_host ctc_host_checker #(
    .IDX_W(IDX_W), .TAG_W(TAG_W), .VALID_BIT(VALID_BIT)
) u_chk (
    .pclk(pclk), .presetn(presetn), .index_in(index_in), .tag_in(tag_in),
    .sel(sel), .sel_n(sel_n), .write_n(write_n), .word_clear_n(word_clear_n),
    .clear_n(clear_n), .out_en_n(out_en_n), .parity_error_n_oe(parity_error_n_oe)
);

// ===== ctc_tb.sv
// testbench: apb-driven tests of the tag store controller against a tag store model
`timescale 1ns/10ps
`include "ctc_map.svh"
module tb;
    // apb side
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, irq, er;
    // tag store pins
    logic [12:0] index_in;
    logic [8:0]  tag_in, tag_out;
    logic        match, sel, sel_n, write_n, word_clear_n, clear_n, out_en_n;
    logic        pe_n, pe_o, pe_oe, pe_pull;
    int          error_cnt = 0;
    int          checked   = 0;

    // pulled-up parity line, low while either party pulls it
    assign pe_n = !((pe_oe && !pe_o) || pe_pull);
    always #50 pclk = ~pclk;

    ctc_host dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq(irq), .index_in(index_in), .tag_in(tag_in), .tag_out(tag_out), .match(match),
        .sel(sel), .sel_n(sel_n), .write_n(write_n), .word_clear_n(word_clear_n),
        .clear_n(clear_n), .out_en_n(out_en_n), .parity_error_n_i(pe_n),
        .parity_error_n_o(pe_o), .parity_error_n_oe(pe_oe)
    );
    ctc_tag_model u_dev (
        .index_in(index_in), .tag_in(tag_in), .tag_out(tag_out), .sel(sel), .sel_n(sel_n),
        .write_n(write_n), .word_clear_n(word_clear_n), .clear_n(clear_n),
        .out_en_n(out_en_n), .match(match), .pe_level_n(pe_n), .pe_pull(pe_pull)
    );

    task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : chk

    // one apb transfer; an idle cycle first so no signal is driven twice in one time step
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // the slave decides the wait; answer taken at the rising edge that sees pready
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp, "read data");
    endtask : rchk

    // clear events, load index and tag, start and wait until idle
    task run(input logic [2:0] op, input logic frc, input logic [12:0] idx, input logic [8:0] tg);
        apb(1'b1, `CTC_REG_INT_STAT, 32'hF);
        apb(1'b1, `CTC_REG_INDEX, {19'h0, idx});
        apb(1'b1, `CTC_REG_TAG, {23'h0, tg});
        apb(1'b1, `CTC_REG_CTRL, {27'h0, frc, op, 1'b1});
        do begin
            apb(1'b0, `CTC_REG_STATUS, 32'h0);
        end while (rd[0] !== 1'b0);
    endtask : run

    // hit and parity flags of status, then the event bits
    task res(input logic [31:0] st, input logic [31:0] ev);
        apb(1'b0, `CTC_REG_STATUS, 32'h0);
        chk(rd & 32'h6, st, "status");
        rchk(`CTC_REG_INT_STAT, ev);
    endtask : res

    task complete_run;
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rchk(`CTC_REG_INT_MASK, 32'h0);
        rchk(`CTC_REG_TAG, 32'h0);
        rchk(8'h1C, 32'h0);
        chk({31'h0, er}, 32'h1, "unmapped error");
        $display("test reset finished");
        run(`CTC_OP_MCLEAR, 1'b0, 13'h0005, 9'h000);
        run(`CTC_OP_COMPARE, 1'b0, 13'h0005, 9'h000);
        res(32'h0, 32'h5);
        run(`CTC_OP_WRITE, 1'b0, 13'h1FFF, 9'h0A5);
        run(`CTC_OP_COMPARE, 1'b0, 13'h1FFF, 9'h0A5);
        res(32'h2, 32'h3);
        run(`CTC_OP_READ, 1'b0, 13'h1FFF, 9'h000);
        rchk(`CTC_REG_RDATA, 32'h1A5);
        run(`CTC_OP_COMPARE, 1'b0, 13'h0000, 9'h0A5);
        res(32'h0, 32'h5);
        run(`CTC_OP_COMPARE, 1'b0, 13'h1FFF, 9'h0A4);
        res(32'h0, 32'h5);
        $display("test write compare finished");
        run(`CTC_OP_WRITE, 1'b0, 13'h0000, 9'h0A5);
        run(`CTC_OP_WCLEAR, 1'b0, 13'h1FFF, 9'h1FF);
        run(`CTC_OP_COMPARE, 1'b0, 13'h1FFF, 9'h0A5);
        res(32'h0, 32'h5);
        run(`CTC_OP_COMPARE, 1'b0, 13'h0000, 9'h0A5);
        res(32'h2, 32'h3);
        $display("test word clear finished");
        run(`CTC_OP_WRITE, 1'b1, 13'h0003, 9'h011);
        run(`CTC_OP_COMPARE, 1'b0, 13'h0003, 9'h011);
        res(32'h4, 32'hD);
        run(`CTC_OP_READ, 1'b0, 13'h0003, 9'h000);
        res(32'h4, 32'h9);
        run(`CTC_OP_WRITE, 1'b0, 13'h0003, 9'h011);
        run(`CTC_OP_COMPARE, 1'b0, 13'h0003, 9'h011);
        res(32'h2, 32'h3);
        $display("test parity finished");
        apb(1'b1, `CTC_REG_INT_MASK, 32'h2);
        run(`CTC_OP_COMPARE, 1'b0, 13'h0003, 9'h011);
        res(32'h2, 32'h3);
        chk({31'h0, irq}, 32'h1, "irq on hit");
        apb(1'b1, `CTC_REG_INT_STAT, 32'h2);
        rchk(`CTC_REG_INT_STAT, 32'h1);
        chk({31'h0, irq}, 32'h0, "irq cleared");
        run(`CTC_OP_COMPARE, 1'b0, 13'h0004, 9'h011);
        res(32'h0, 32'h5);
        chk({31'h0, irq}, 32'h0, "masked miss");
        $display("test interrupt finished");
        run(`CTC_OP_MCLEAR, 1'b0, 13'h0000, 9'h000);
        run(`CTC_OP_COMPARE, 1'b0, 13'h0003, 9'h011);
        res(32'h0, 32'h5);
        $display("test master clear finished");
        complete_run();
    end

    // cut a hang short well beyond the expected length of the run
    initial begin
        repeat (5000) @(posedge pclk);
        error_cnt++;
        complete_run();
    end
endmodule : tb
